// File: logic/spmsp_core.sv
`timescale 1ns/1ns
// Function
// - Master mode when enable and master enable bits both set.
// - Data write in master mode starts transfer.
// - Done flag set when transfer completes.
// - Interrupt request raised while done flag set.
// - Master frame length one to eight bits.
// - Full duplex; received bits replace data.
// - Master write during transfer ignored, sets collision flag.
// - Data reads return double-buffered receive buffer.
// - Unread buffer at end sets overrun, keeps old.
// - Enabled without master enable means slave.
// - Slave done when select returns high.
// - Slave write loads next frame's shift data.
// - Select low as master: fault, go off-line.
// - Phase bit picks first or second edge.
// - Polarity bit picks clock idle level.
// - Clock rate register sets master clock only.
// - Data shifted most significant bit first.
// - Slave output released when not selected.
// - Master bit rate at most half system clock.
module spmsp_core (
  input wire logic sys_clk,
  input wire logic srst,
  input wire spmsp_pkg::spmsp_sfr_s sfr,
  output logic [7:0] sfr_rdata,
  output logic irq_req,
  input wire logic slave_sck,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic slave_select_n
);
  // Register address match, shared by the write and data-read strobe decodes.
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  logic data_wr, data_rd, ctrl_wr, cfg_wr, ckr_wr;
  logic done, write_collision_flag, mode_fault_flag, ovr, mstr, en;
  logic next_done, next_write_collision_flag, next_mode_fault_flag, next_ovr, next_mstr, next_en;
  logic cfg_cpha, cfg_cpol, next_cpha, next_cpol;
  logic [2:0] cfg_frs, next_frs;
  logic [7:0] ckr, next_ckr;
  logic [7:0] rx_buf, next_rx_buf;
  logic rx_full, next_full;
  logic [7:0] msh, next_msh, mrx, next_mrx;
  logic [7:0] slv_tx, next_slv_tx, slv_pend, next_slv_pend;
  logic pend_valid, next_pend_valid;
  spmsp_pkg::spmsp_state_e state, next_state;
  logic [7:0] div_cnt, next_div;
  logic [3:0] edge_cnt, next_edge;
  logic master_sck, next_master_sck;
  logic [7:0] next_rdata;
  logic nss_s1, nss_s2, nss_s3, nss_lvl, next_nss_lvl, nss_prev;
  logic miso_s1, miso_s2, miso_s3, miso_lvl, next_miso_lvl;
  logic master_mode, slave_mode, mode_fault, master_done, slave_done;
  logic xfer_done, full_eff;
  logic [7:0] word, slave_rx;
  logic [3:0] last_edge;
  logic lead, sample_rising;

  assign data_wr = sfr.wr && addr_hit(sfr.addr, spmsp_pkg::DATA_ADDR);
  assign data_rd = sfr.rd && addr_hit(sfr.addr, spmsp_pkg::DATA_ADDR);
  assign ctrl_wr = sfr.wr && addr_hit(sfr.addr, spmsp_pkg::CTRL_ADDR);
  assign cfg_wr = sfr.wr && addr_hit(sfr.addr, spmsp_pkg::CFG_ADDR);
  assign ckr_wr = sfr.wr && addr_hit(sfr.addr, spmsp_pkg::CKR_ADDR);

  // Mode decode and the events that drive the flags.
  assign master_mode = en && mstr;
  assign slave_mode = en && !mstr;
  assign mode_fault = mstr && !nss_lvl;
  assign slave_done = slave_mode && nss_lvl && !nss_prev;
  assign last_edge = {cfg_frs, 1'b1};
  assign lead = !edge_cnt[0];
  assign full_eff = rx_full && !data_rd;
  assign xfer_done = master_done || slave_done;
  assign irq_req = done;

  // Pin outputs; the master clock idles at the polarity level between frames.
  assign sck_out = master_sck;
  assign sck_oe = master_mode;
  assign mosi_out = msh[7];
  assign mosi_oe = master_mode;
  assign miso_oe = slave_mode && !slave_select_n;

  // Next-state logic for everything on the system clock.
  always_comb begin
    next_done = done;
    next_write_collision_flag = write_collision_flag;
    next_mode_fault_flag = mode_fault_flag;
    next_ovr = ovr;
    next_mstr = mstr;
    next_en = en;
    next_cpha = cfg_cpha;
    next_cpol = cfg_cpol;
    next_frs = cfg_frs;
    next_ckr = ckr;
    next_rx_buf = rx_buf;
    next_full = rx_full;
    next_msh = msh;
    next_mrx = mrx;
    next_slv_tx = slv_tx;
    next_slv_pend = slv_pend;
    next_pend_valid = pend_valid;
    next_state = state;
    next_div = div_cnt;
    next_edge = edge_cnt;
    next_master_sck = master_sck;
    master_done = 1'b0;
    word = slave_rx;
    next_rdata = 8'h00;
    if (ctrl_wr) begin
      next_done = sfr.wdata[spmsp_pkg::CTL_DONE];
      next_write_collision_flag = sfr.wdata[spmsp_pkg::CTL_WRITE_COLLISION_FLAG];
      next_mode_fault_flag = sfr.wdata[spmsp_pkg::CTL_MODE_FAULT_FLAG];
      next_ovr = sfr.wdata[spmsp_pkg::CTL_OVR];
      next_mstr = sfr.wdata[spmsp_pkg::CTL_MASTER_ENABLE_BIT];
      next_en = sfr.wdata[spmsp_pkg::CTL_EN];
    end
    if (cfg_wr) begin
      next_cpha = sfr.wdata[spmsp_pkg::CFG_CPHA];
      next_cpol = sfr.wdata[spmsp_pkg::CFG_CPOL];
      next_frs = sfr.wdata[spmsp_pkg::CFG_FRS_LSB +: 3];
    end
    if (ckr_wr) begin
      next_ckr = sfr.wdata;
    end
    // Master sequencer: one sck toggle every ckr+1 cycles, so a bit takes two or more.
    case (state)
      spmsp_pkg::SPMSP_IDLE: begin
        next_master_sck = cfg_cpol;
        next_div = 8'h00;
        next_edge = 4'h0;
        if (data_wr && master_mode) begin
          next_state = spmsp_pkg::SPMSP_RUN;
          next_msh = sfr.wdata;
          next_mrx = 8'h00;
        end
      end
      spmsp_pkg::SPMSP_RUN: begin
        if (data_wr) begin
          next_write_collision_flag = 1'b1;
        end
        if (div_cnt == ckr) begin
          next_div = 8'h00;
          next_master_sck = !master_sck;
          next_edge = edge_cnt + 4'h1;
          if (lead != cfg_cpha) begin
            next_mrx = {mrx[6:0], miso_lvl};
          end else if (edge_cnt != 4'h0) begin
            next_msh = {msh[6:0], 1'b0};
          end
          if (edge_cnt == last_edge) begin
            next_state = spmsp_pkg::SPMSP_IDLE;
            master_done = 1'b1;
          end
        end else begin
          next_div = div_cnt + 8'h01;
        end
      end
      default: begin
        next_state = spmsp_pkg::SPMSP_IDLE;
      end
    endcase
    // Slave writes made inside a frame wait for its end, so the old byte goes out.
    if (data_wr && slave_mode) begin
      if (nss_lvl) begin
        next_slv_tx = sfr.wdata;
      end else begin
        next_slv_pend = sfr.wdata;
        next_pend_valid = 1'b1;
      end
    end
    if (slave_done && pend_valid) begin
      next_slv_tx = slv_pend;
      next_pend_valid = 1'b0;
    end
    // Completion; hardware set is applied after the software write so it wins.
    if (data_rd) begin
      next_full = 1'b0;
    end
    if (master_done) begin
      word = next_mrx;
    end
    if (xfer_done) begin
      next_done = 1'b1;
      if (full_eff) begin
        next_ovr = 1'b1;
      end else begin
        next_rx_buf = word;
        next_full = 1'b1;
      end
    end
    if (mode_fault) begin
      next_mode_fault_flag = 1'b1;
      next_mstr = 1'b0;
      next_en = 1'b0;
      next_state = spmsp_pkg::SPMSP_IDLE;
      next_master_sck = cfg_cpol;
    end
    if (sfr.rd) begin
      case (sfr.addr)
        spmsp_pkg::CTRL_ADDR: begin
          next_rdata = {done, write_collision_flag, mode_fault_flag, ovr, state == spmsp_pkg::SPMSP_RUN,
                        !nss_lvl, mstr, en};
        end
        spmsp_pkg::DATA_ADDR: begin
          next_rdata = rx_buf;
        end
        spmsp_pkg::CFG_ADDR: begin
          next_rdata = {cfg_cpha, cfg_cpol, edge_cnt[3:1], cfg_frs};
        end
        spmsp_pkg::CKR_ADDR: begin
          next_rdata = ckr;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  // Pin synchronisers: a change is taken once the second and third stage agree.
  always_comb begin
    next_nss_lvl = (nss_s2 == nss_s3) ? nss_s3 : nss_lvl;
    next_miso_lvl = (miso_s2 == miso_s3) ? miso_s3 : miso_lvl;
  end

  // System-clock registers.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      {done, write_collision_flag, mode_fault_flag, ovr} <= spmsp_pkg::CTRL_RST[7:4];
      mstr <= spmsp_pkg::CTRL_RST[spmsp_pkg::CTL_MASTER_ENABLE_BIT];
      en <= spmsp_pkg::CTRL_RST[spmsp_pkg::CTL_EN];
      cfg_cpha <= spmsp_pkg::CFG_RST[spmsp_pkg::CFG_CPHA];
      cfg_cpol <= spmsp_pkg::CFG_RST[spmsp_pkg::CFG_CPOL];
      cfg_frs <= spmsp_pkg::CFG_RST[2:0];
      ckr <= spmsp_pkg::CKR_RST;
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
      msh <= 8'h00;
      mrx <= 8'h00;
      slv_tx <= 8'h00;
      slv_pend <= 8'h00;
      pend_valid <= 1'b0;
      state <= spmsp_pkg::SPMSP_IDLE;
      div_cnt <= 8'h00;
      edge_cnt <= 4'h0;
      master_sck <= 1'b0;
      sfr_rdata <= 8'h00;
      {nss_s1, nss_s2, nss_s3, nss_lvl, nss_prev} <= 5'h1F;
      {miso_s1, miso_s2, miso_s3, miso_lvl} <= 4'h0;
    end else begin
      {done, write_collision_flag, mode_fault_flag, ovr} <= {next_done, next_write_collision_flag, next_mode_fault_flag, next_ovr};
      mstr <= next_mstr;
      en <= next_en;
      cfg_cpha <= next_cpha;
      cfg_cpol <= next_cpol;
      cfg_frs <= next_frs;
      ckr <= next_ckr;
      rx_buf <= next_rx_buf;
      rx_full <= next_full;
      msh <= next_msh;
      mrx <= next_mrx;
      slv_tx <= next_slv_tx;
      slv_pend <= next_slv_pend;
      pend_valid <= next_pend_valid;
      state <= next_state;
      div_cnt <= next_div;
      edge_cnt <= next_edge;
      master_sck <= next_master_sck;
      sfr_rdata <= next_rdata;
      {nss_s1, nss_s2, nss_s3} <= {slave_select_n, nss_s1, nss_s2};
      nss_lvl <= next_nss_lvl;
      nss_prev <= nss_lvl;
      {miso_s1, miso_s2, miso_s3} <= {miso_in, miso_s1, miso_s2};
      miso_lvl <= next_miso_lvl;
    end
  end

  // Slave side on the external clock. Counters are cleared by the deasserted select;
  // the sample words are not, so they still hold the frame when the system side reads them.
  logic [3:0] pos_cnt, neg_cnt, next_pos_cnt, next_neg_cnt, shift_cnt, sel;
  logic [7:0] pos_rx, neg_rx, next_pos_rx, next_neg_rx;
  assign sample_rising = (cfg_cpol == cfg_cpha);
  assign slave_rx = sample_rising ? pos_rx : neg_rx;
  assign shift_cnt = sample_rising ? neg_cnt : pos_cnt;

  always_comb begin
    next_pos_cnt = (pos_cnt == 4'hF) ? pos_cnt : pos_cnt + 4'h1;
    next_neg_cnt = (neg_cnt == 4'hF) ? neg_cnt : neg_cnt + 4'h1;
    next_pos_rx = sample_rising ? {pos_rx[6:0], mosi_in} : pos_rx;
    next_neg_rx = sample_rising ? neg_rx : {neg_rx[6:0], mosi_in};
    sel = 4'h7 + {3'b000, cfg_cpha} - shift_cnt;
    miso_out = (sel > 4'h7) ? slv_tx[7] : slv_tx[sel[2:0]];
  end

  always_ff @(posedge slave_sck or posedge slave_select_n) begin
    if (slave_select_n) begin
      pos_cnt <= 4'h0;
    end else begin
      pos_cnt <= next_pos_cnt;
    end
  end

  always_ff @(negedge slave_sck or posedge slave_select_n) begin
    if (slave_select_n) begin
      neg_cnt <= 4'h0;
    end else begin
      neg_cnt <= next_neg_cnt;
    end
  end

  always_ff @(posedge slave_sck) begin
    pos_rx <= next_pos_rx;
  end

  always_ff @(negedge slave_sck) begin
    neg_rx <= next_neg_rx;
  end

  property p_start;
    @(posedge sys_clk) disable iff (srst)
    (state == spmsp_pkg::SPMSP_IDLE && data_wr && master_mode && !mode_fault)
      |=> (state == spmsp_pkg::SPMSP_RUN && msh == $past(sfr.wdata));
  endproperty
  a_start: assert property (p_start)
    else $error("Master data write did not start a transfer.");

  property p_write_collision_flag;
    @(posedge sys_clk) disable iff (srst)
    (state == spmsp_pkg::SPMSP_RUN && data_wr && !ctrl_wr) |=> (write_collision_flag && $stable(msh[6:0]) ||
      write_collision_flag && $past(div_cnt == ckr));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("Write during transfer did not set the collision flag.");

  property p_mode_fault_flag;
    @(posedge sys_clk) disable iff (srst)
    mode_fault |=> (mode_fault_flag && !mstr && !en && state == spmsp_pkg::SPMSP_IDLE);
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag)
    else $error("Mode fault did not take the port off-line.");

  property p_done;
    @(posedge sys_clk) disable iff (srst)
    xfer_done |=> done ##0 irq_req;
  endproperty
  a_done: assert property (p_done)
    else $error("Completed transfer did not raise the done flag.");

  property p_ovr;
    @(posedge sys_clk) disable iff (srst)
    (xfer_done && full_eff) |=> (ovr && rx_buf == $past(rx_buf));
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("Overrun did not keep the old byte and flag it.");

  property p_idle_sck;
    @(posedge sys_clk) disable iff (srst)
    (state == spmsp_pkg::SPMSP_IDLE) ##1 (state == spmsp_pkg::SPMSP_IDLE)
      |-> master_sck == $past(cfg_cpol);
  endproperty
  a_idle_sck: assert property (p_idle_sck)
    else $error("Master clock not at idle level between transfers.");

  property p_rate;
    @(posedge sys_clk) disable iff (srst)
    (state == spmsp_pkg::SPMSP_RUN && div_cnt != ckr && !mode_fault)
      |=> $stable(master_sck);
  endproperty
  a_rate: assert property (p_rate)
    else $error("Master clock toggled before the rate count expired.");

  property p_slave_done;
    @(posedge sys_clk) disable iff (srst)
    (slave_mode && !nss_prev && nss_lvl && !full_eff) |=> (done && rx_full && rx_buf == $past(slave_rx));
  endproperty
  a_slave_done: assert property (p_slave_done)
    else $error("Slave frame end did not deliver the byte.");
endmodule

// File: logic/spmsp_pkg.sv
package spmsp_pkg;
  // Register addresses on the special-function-register bus.
  localparam logic [7:0] CTRL_ADDR = 8'hF8;
  localparam logic [7:0] DATA_ADDR = 8'h9B;
  localparam logic [7:0] CFG_ADDR = 8'h9A;
  localparam logic [7:0] CKR_ADDR = 8'h9D;

  // Control register field positions.
  localparam int CTL_DONE = 7;
  localparam int CTL_WRITE_COLLISION_FLAG = 6;
  localparam int CTL_MODE_FAULT_FLAG = 5;
  localparam int CTL_OVR = 4;
  localparam int CTL_BUSY = 3;
  localparam int CTL_SLAVE_SELECTED_FLAG = 2;
  localparam int CTL_MASTER_ENABLE_BIT = 1;
  localparam int CTL_EN = 0;

  // Config register field positions.
  localparam int CFG_CPHA = 7;
  localparam int CFG_CPOL = 6;
  localparam int CFG_BC_LSB = 3;
  localparam int CFG_FRS_LSB = 0;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h07;
  localparam logic [7:0] CKR_RST = 8'h00;

  // Master transfer sequencer states.
  typedef enum logic [1:0] {
    SPMSP_IDLE = 2'b01,
    SPMSP_RUN = 2'b10
  } spmsp_state_e;

  // One register bus request, all fields valid in the same cycle.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } spmsp_sfr_s;
endpackage

// File: tb/spmsp_core_test.sv
`timescale 1ns/1ns
module spmsp_core_test;
  logic sys_clk;
  logic srst;
  spmsp_pkg::spmsp_sfr_s sfr;
  logic [7:0] sfr_rdata;
  logic irq_req, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic p_sck, p_mosi, p_miso, ss_n, cpol, cpha;
  logic sck_w, mosi_w, miso_w;
  int bad_count, cmp_count, cyc;

  // Each shared wire follows whichever party has its driver enabled.
  assign sck_w = sck_oe ? sck_out : p_sck;
  assign mosi_w = mosi_oe ? mosi_out : p_mosi;
  assign miso_w = miso_oe ? miso_out : p_miso;

  spmsp_core dut (
    .sys_clk(sys_clk),
    .srst(srst),
    .sfr(sfr),
    .sfr_rdata(sfr_rdata),
    .irq_req(irq_req),
    .slave_sck(sck_w),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .mosi_in(mosi_w),
    .mosi_out(mosi_out),
    .mosi_oe(mosi_oe),
    .miso_in(miso_w),
    .miso_out(miso_out),
    .miso_oe(miso_oe),
    .slave_select_n(ss_n)
  );

  spmsp_partner p (
    .sck(sck_w),
    .mosi(mosi_w),
    .miso_dut(miso_w),
    .cpol(cpol),
    .cpha(cpha),
    .miso(p_miso),
    .m_sck(p_sck),
    .m_mosi(p_mosi),
    .ss_n(ss_n)
  );

  // System clock, 10 ns period.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Register writes and reads are one-cycle strobes launched at the falling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    sfr = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge sys_clk);
    sfr.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    sfr = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge sys_clk);
    sfr.rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  // Polls the done flag; the read never clears it, so polling is harmless.
  task automatic wait_done();
    logic [7:0] v;
    int n;
    n = 0;
    v = 8'h00;
    while (v[7] !== 1'b1 && n < 200) begin
      rd(spmsp_pkg::CTRL_ADDR, v);
      n++;
    end
    // A flag that never comes counts as a mismatch rather than a silent fall-through.
    chk({7'h00, v[7]}, 8'h01);
  endtask

  // Reset, then master, slave and fault scenarios in turn.
  initial begin
    sfr = '0;
    srst = 1'b1;
    cpol = 1'b0;
    cpha = 1'b0;
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    rdchk(spmsp_pkg::CTRL_ADDR, spmsp_pkg::CTRL_RST);
    rdchk(spmsp_pkg::CFG_ADDR, spmsp_pkg::CFG_RST);
    rdchk(spmsp_pkg::CKR_ADDR, spmsp_pkg::CKR_RST);
    rdchk(8'h10, 8'h00);
    // Eight-bit master transfer; the second data write lands mid-transfer.
    // The returned bit crosses a three-stage synchroniser, so a half period of five
    // system cycles is the shortest that lets each bit settle before it is sampled.
    wr(spmsp_pkg::CKR_ADDR, 8'h04);
    wr(spmsp_pkg::CTRL_ADDR, 8'h03);
    chk({6'h00, sck_oe, mosi_oe}, 8'h03);
    p.arm(8'h3C);
    wr(spmsp_pkg::DATA_ADDR, 8'hA5);
    wr(spmsp_pkg::DATA_ADDR, 8'hFF);
    rdchk(spmsp_pkg::CTRL_ADDR, 8'h4B);
    wait_done();
    chk(p.rx, 8'hA5);
    rdchk(spmsp_pkg::CTRL_ADDR, 8'hC3);
    chk({7'h00, irq_req}, 8'h01);
    chk({7'h00, sck_out}, 8'h00);
    rdchk(spmsp_pkg::DATA_ADDR, 8'h3C);
    wr(spmsp_pkg::CTRL_ADDR, 8'h03);
    chk({7'h00, irq_req}, 8'h00);
    // Settings change only with the port off; then a four-bit frame, second-edge sampling.
    wr(spmsp_pkg::CTRL_ADDR, 8'h00);
    wr(spmsp_pkg::CFG_ADDR, 8'hC3);
    cpol = 1'b1;
    cpha = 1'b1;
    wr(spmsp_pkg::CTRL_ADDR, 8'h03);
    rdchk(spmsp_pkg::CTRL_ADDR, 8'h03);
    chk({7'h00, sck_out}, 8'h01);
    p.arm(8'hB0);
    wr(spmsp_pkg::DATA_ADDR, 8'h96);
    wait_done();
    chk(p.rx, 8'h09);
    // The buffer is left unread, so the next byte must be dropped.
    wr(spmsp_pkg::CTRL_ADDR, 8'h03);
    p.arm(8'h70);
    wr(spmsp_pkg::DATA_ADDR, 8'h50);
    wait_done();
    rdchk(spmsp_pkg::CTRL_ADDR, 8'h93);
    rdchk(spmsp_pkg::DATA_ADDR, 8'h0B);
    // Slave frame; the small frame size and the rate setting must both be ignored.
    wr(spmsp_pkg::CTRL_ADDR, 8'h00);
    wr(spmsp_pkg::CFG_ADDR, 8'h03);
    cpol = 1'b0;
    cpha = 1'b0;
    wr(spmsp_pkg::CTRL_ADDR, 8'h01);
    chk({6'h00, sck_oe, mosi_oe}, 8'h00);
    chk({7'h00, miso_oe}, 8'h00);
    wr(spmsp_pkg::DATA_ADDR, 8'h5A);
    p.frame(8'hC3);
    chk(p.mrx, 8'h5A);
    wait_done();
    rdchk(spmsp_pkg::CTRL_ADDR, 8'h81);
    rdchk(spmsp_pkg::DATA_ADDR, 8'hC3);
    wr(spmsp_pkg::CTRL_ADDR, 8'h01);
    // A write made inside a frame is too late: the old byte goes out, the new one next time.
    fork
      p.frame(8'h3D);
      begin
        repeat (6) @(negedge sys_clk);
        wr(spmsp_pkg::DATA_ADDR, 8'hE7);
      end
    join
    chk(p.mrx, 8'h5A);
    wait_done();
    rdchk(spmsp_pkg::DATA_ADDR, 8'h3D);
    wr(spmsp_pkg::CTRL_ADDR, 8'h01);
    p.frame(8'h00);
    chk(p.mrx, 8'hE7);
    wait_done();
    // Select pulled low under a master: fault, and the port drops off-line.
    wr(spmsp_pkg::CTRL_ADDR, 8'h03);
    p.hold_sel(1'b0);
    repeat (6) @(negedge sys_clk);
    rdchk(spmsp_pkg::CTRL_ADDR, 8'h24);
    p.hold_sel(1'b1);
    repeat (6) @(negedge sys_clk);
    rdchk(spmsp_pkg::CTRL_ADDR, 8'h20);
    tally_and_finish();
  end
endmodule

// File: tb/spmsp_partner.sv
`timescale 1ns/1ns
// Far side of the serial port: a plain slave for master transfers and a plain master for
// slave frames. Released lines show the inverse of their last value so stale bits never pass.
module spmsp_partner (
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso_dut,
  input wire logic cpol,
  input wire logic cpha,
  output logic miso,
  output logic m_sck,
  output logic m_mosi,
  output logic ss_n
);
  logic [7:0] tx;
  logic [7:0] rx;
  logic [7:0] mrx;
  logic act;
  int sh;
  int i;

  // Idle levels at time zero; the slave role listens only once armed. The select line
  // rises just after time zero so the port's serial counters always see their clear edge.
  initial begin
    act = 1'b0;
    miso = 1'b0;
    m_sck = 1'b0;
    m_mosi = 1'b0;
    ss_n = 1'b0;
    #1;
    ss_n = 1'b1;
  end

  // Loads the reply byte for the next master transfer.
  task automatic arm(input logic [7:0] b);
    tx = b;
    rx = 8'h00;
    sh = 0;
    act = 1'b1;
    miso = cpha ? ~miso : b[7];
  endtask

  // The leading edge leaves the idle level; the phase picks which edge samples.
  always @(sck) begin
    if (act) begin
      if ((sck != cpol) != cpha) begin
        rx = {rx[6:0], mosi};
      end else begin
        sh = sh + 1;
        i = 7 - sh + (cpha ? 1 : 0);
        miso = (i >= 0) ? tx[i] : ~miso;
      end
    end
  end

  // Drives the select line outside a frame, as a rival master would.
  task automatic hold_sel(input logic lvl);
    ss_n = lvl;
  endtask

  // One mode-0 frame as bus master; the clock stands still outside the frame.
  task automatic frame(input logic [7:0] b);
    act = 1'b0;
    mrx = 8'h00;
    ss_n = 1'b0;
    #20;
    for (int k = 7; k >= 0; k--) begin
      m_mosi = b[k];
      #7;
      m_sck = 1'b1;
      mrx = {mrx[6:0], miso_dut};
      #8;
      m_sck = 1'b0;
    end
    #10;
    ss_n = 1'b1;
    m_mosi = ~m_mosi;
  endtask
endmodule
